// [logic/crs_pkg.sv]
// Purpose: shared constants and types for the cascaded rail sequencer
// Assumes: core clock at 10 MHz
// Notes:   times kept in their own unit, cycle counts derived from them
package crs_pkg;
  localparam int CLK_HZ            = 10_000_000;
  localparam int CHANNELS          = 4;
  localparam int DELAY_W           = 24;
  // times in microseconds, as printed
  localparam int LOCKOUT_US        = 10_000;
  localparam int TOTAL_DONE_US     = 160_000;
  localparam int DONE_REL_US       = TOTAL_DONE_US - LOCKOUT_US;
  localparam int FAULT_PULSE_US    = 10;
  localparam int LOCKOUT_CYC       = (LOCKOUT_US * (CLK_HZ / 1_000_000));
  localparam int DONE_REL_CYC      = (DONE_REL_US * (CLK_HZ / 1_000_000));
  localparam int FAULT_PULSE_CYC   = (FAULT_PULSE_US * (CLK_HZ / 1_000_000));
  localparam logic [DELAY_W-1:0] DELAY_ZERO = 24'h000000;
  localparam logic [DELAY_W-1:0] DELAY_ONE  = 24'h000001;

  typedef enum logic [2:0] {
    CRS_IDLE,
    CRS_LOCKOUT,
    CRS_RAMP_ON,
    CRS_SETTLE,
    CRS_DONE,
    CRS_RAMP_OFF
  } crs_state_e;

  // one channel's programmed delays
  typedef struct packed {
    logic [DELAY_W-1:0] onDelay;
    logic [DELAY_W-1:0] offDelay;
  } crs_chan_cfg_s;
endpackage : crs_pkg

// [logic/crs_chan_timer.sv]
// Purpose: one channel's turn-on / turn-off delay and output latch
// Assumes: start pulses come from the sequencer state machine
// Notes:   delay of N cycles means output moves N cycles after start
`timescale 1ns/1ps
module crs_chan_timer
  import crs_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic          rst,
  input  wire crs_chan_cfg_s cfg,
  input  wire logic          startOn,
  input  wire logic          startOff,
  input  wire logic          forceOff,
  output logic               chanOn,
  output logic               busy
);
  logic [DELAY_W-1:0] cnt;
  logic               runOn;
  logic               runOff;
  logic [DELAY_W-1:0] next_cnt;
  logic               next_runOn;
  logic               next_runOff;
  logic               next_chanOn;

  always_comb begin
    next_cnt    = cnt;
    next_runOn  = runOn;
    next_runOff = runOff;
    next_chanOn = chanOn;
    if (forceOff) begin
      next_runOn  = 1'b0;
      next_runOff = 1'b0;
      next_chanOn = 1'b0;
    end else if (startOn) begin
      next_runOff = 1'b0;
      if (cfg.onDelay == DELAY_ZERO) begin
        next_chanOn = 1'b1;
        next_runOn  = 1'b0;
      end else begin
        next_runOn = 1'b1;
        next_cnt   = cfg.onDelay - DELAY_ONE;
      end
    end else if (startOff) begin
      next_runOn = 1'b0;
      if (cfg.offDelay == DELAY_ZERO) begin
        next_chanOn = 1'b0;
        next_runOff = 1'b0;
      end else begin
        next_runOff = 1'b1;
        next_cnt    = cfg.offDelay - DELAY_ONE;
      end
    end else if (runOn || runOff) begin
      if (cnt == DELAY_ZERO) begin
        next_chanOn = runOn;
        next_runOn  = 1'b0;
        next_runOff = 1'b0;
      end else begin
        next_cnt = cnt - DELAY_ONE;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt    <= DELAY_ZERO;
      runOn  <= 1'b0;
      runOff <= 1'b0;
      chanOn <= 1'b0;
    end else begin
      cnt    <= next_cnt;
      runOn  <= next_runOn;
      runOff <= next_runOff;
      chanOn <= next_chanOn;
    end
  end

  assign busy = runOn | runOff;
endmodule : crs_chan_timer

// [logic/crs_sequencer.sv]
// Purpose: four-channel power-rail sequencer for cascaded use
// Assumes: all inputs synchronous to core_clk; fault bus wired-low outside
// Notes:   analogue delays become cycle counts per channel
`timescale 1ns/1ps
module crs_sequencer
  import crs_pkg::*;
#(
  parameter int LOCKOUT_CYCLES  = LOCKOUT_CYC,
  parameter int DONE_REL_CYCLES = DONE_REL_CYC
)
(
  input  wire logic          core_clk,
  input  wire logic          rst,
  input  wire logic          enable,
  input  wire logic [3:0]    undervoltage_ok_input,
  input  wire crs_chan_cfg_s chanCfg [CHANNELS],
  input  wire logic          shared_fault_bus_n_in,
  output logic               shared_fault_bus_n_out,
  output logic               shared_fault_bus_n_oe,
  output logic [3:0]         chanEnable,
  output logic               seqDone
);
  localparam logic [31:0] LOCK_LAST  = 32'(LOCKOUT_CYCLES - 1);
  localparam logic [31:0] REL_LAST   = 32'(DONE_REL_CYCLES - 1);
  localparam logic [31:0] PULSE_LAST = 32'(FAULT_PULSE_CYC - 1);
  localparam logic [31:0] CNT_ZERO   = 32'h00000000;
  localparam logic [31:0] CNT_ONE    = 32'h00000001;

  crs_state_e  state;
  crs_state_e  next_state;
  logic [31:0] tmr;
  logic [31:0] next_tmr;
  logic [31:0] pulseCnt;
  logic [31:0] next_pulseCnt;
  logic        pulsing;
  logic        next_pulsing;
  logic        next_seqDone;
  logic        startOn;
  logic        startOff;
  logic        forceOff;
  logic [3:0]  chanBusy;
  logic        allUvOk;
  logic        faultSeen;

  assign allUvOk   = &undervoltage_ok_input;
  // own pulse counts too: the wire reads low while we pull it
  assign faultSeen = ~shared_fault_bus_n_in;

  always_comb begin
    next_state    = state;
    next_tmr      = tmr;
    next_seqDone  = seqDone;
    next_pulsing  = pulsing;
    next_pulseCnt = pulseCnt;
    startOn       = 1'b0;
    startOff      = 1'b0;
    forceOff      = 1'b0;
    // fault pulse generator, armed only once sequence has completed
    if (pulsing) begin
      if (pulseCnt == CNT_ZERO) begin
        next_pulsing = 1'b0;
      end else begin
        next_pulseCnt = pulseCnt - CNT_ONE;
      end
    end else if (state == CRS_DONE && !allUvOk) begin
      next_pulsing  = 1'b1;
      next_pulseCnt = PULSE_LAST;
    end
    unique case (state)
      CRS_IDLE: begin
        if (enable && allUvOk && !faultSeen) begin
          next_state = CRS_LOCKOUT;
          next_tmr   = LOCK_LAST;
        end
      end
      CRS_LOCKOUT: begin
        if (!enable || !allUvOk) begin
          next_state = CRS_IDLE;
        end else if (tmr == CNT_ZERO) begin
          next_state = CRS_RAMP_ON;
          startOn    = 1'b1;
        end else begin
          next_tmr = tmr - CNT_ONE;
        end
      end
      CRS_RAMP_ON: begin
        if (!enable) begin
          next_state = CRS_RAMP_OFF;
          startOff   = 1'b1;
        end else if (!allUvOk) begin
          next_state = CRS_IDLE;
          forceOff   = 1'b1;
        end else if (chanBusy == 4'h0 && &chanEnable) begin
          next_state = CRS_SETTLE;
          next_tmr   = REL_LAST;
        end
      end
      CRS_SETTLE: begin
        if (!enable) begin
          next_state = CRS_RAMP_OFF;
          startOff   = 1'b1;
        end else if (!allUvOk) begin
          next_state = CRS_IDLE;
          forceOff   = 1'b1;
        end else if (tmr == CNT_ZERO) begin
          next_state   = CRS_DONE;
          next_seqDone = 1'b1;
        end else begin
          next_tmr = tmr - CNT_ONE;
        end
      end
      CRS_DONE: begin
        if (!enable) begin
          next_state = CRS_RAMP_OFF;
          startOff   = 1'b1;
        end
      end
      CRS_RAMP_OFF: begin
        if (enable && allUvOk) begin
          next_state = CRS_LOCKOUT;
          next_tmr   = LOCK_LAST;
          forceOff   = 1'b0;
        end else if (chanBusy == 4'h0) begin
          next_state = CRS_IDLE;
        end
      end
    endcase
    if (!enable || !allUvOk) begin
      next_seqDone = 1'b0;
    end
    if (faultSeen) begin
      forceOff     = 1'b1;
      startOn      = 1'b0;
      startOff     = 1'b0;
      next_state   = CRS_IDLE;
      next_seqDone = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state    <= CRS_IDLE;
      tmr      <= CNT_ZERO;
      seqDone  <= 1'b0;
      pulsing  <= 1'b0;
      pulseCnt <= CNT_ZERO;
    end else begin
      state    <= next_state;
      tmr      <= next_tmr;
      seqDone  <= next_seqDone;
      pulsing  <= next_pulsing;
      pulseCnt <= next_pulseCnt;
    end
  end

  // open-drain: only ever pulls low
  assign shared_fault_bus_n_out = 1'b0;
  assign shared_fault_bus_n_oe  = pulsing;

  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
    crs_chan_timer u_timer (
      .core_clk (core_clk),
      .rst      (rst),
      .cfg      (chanCfg[ch]),
      .startOn  (startOn),
      .startOff (startOff),
      .forceOff (forceOff),
      .chanOn   (chanEnable[ch]),
      .busy     (chanBusy[ch])
    );
  end
endmodule : crs_sequencer

// [bench/crs_far_side.sv]
// Purpose: far side of the sequencer: enable logic and fault bus
// Assumes: bus has a pull-up
// Notes:   nbrPull stands for a neighbouring device
`timescale 1ns/1ps
module crs_far_side (
  input  wire logic [1:0] railUp,
  input  wire logic       devOe,
  input  wire logic       nbrPull,
  output logic            seqEnable,
  output logic            busN
);
  assign seqEnable = &railUp;
  // released bus floats up through the pull-up
  assign busN = !(devOe || nbrPull);
endmodule : crs_far_side

// [bench/crs_seq_chk.sv]
// Purpose: port checks for crs_sequencer
// Assumes: one clock, rst async high
// Notes:   bound to every instance
`timescale 1ns/1ps
module crs_seq_chk
  import crs_pkg::*;
#(parameter int DONE_REL_CYCLES = DONE_REL_CYC)
(
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       enable,
  input wire logic [3:0] undervoltage_ok_input,
  input wire logic       shared_fault_bus_n_in,
  input wire logic       shared_fault_bus_n_oe,
  input wire logic [3:0] chanEnable,
  input wire logic       seqDone
);
  int onCnt, next_onCnt, oeLen, next_oeLen;
  wire logic fo = shared_fault_bus_n_oe;
  wire logic busN = shared_fault_bus_n_in;
  wire logic uvOk = &undervoltage_ok_input;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  always_comb begin
    next_onCnt = (&chanEnable && enable) ? onCnt + 1 : 0;
    next_oeLen = fo ? oeLen + 1 : 0;
  end
  always_ff @(posedge core_clk or posedge rst) begin
    onCnt <= rst ? 0 : next_onCnt;
    oeLen <= rst ? 0 : next_oeLen;
  end
  property p_fault_off; !busN |=> chanEnable == 4'h0 && !seqDone; endproperty
  a_fault_off: assert property (p_fault_off) else $error("outputs on after bus low");
  property p_dis_done; !enable |=> !seqDone; endproperty
  a_dis_done: assert property (p_dis_done) else $error("done high while disabled");
  property p_lockout; $rose(enable) && chanEnable == 4'h0 |=> (chanEnable == 4'h0) [*8]; endproperty
  a_lockout: assert property (p_lockout) else $error("channel on inside lockout");
  property p_rel_min; $rose(seqDone) |-> onCnt >= DONE_REL_CYCLES; endproperty
  a_rel_min: assert property (p_rel_min) else $error("done released early");
  property p_rel_max; onCnt == DONE_REL_CYCLES + 8 && uvOk && busN |-> seqDone; endproperty
  a_rel_max: assert property (p_rel_max) else $error("done released late");
  property p_done_all; seqDone |-> &chanEnable; endproperty
  a_done_all: assert property (p_done_all) else $error("done without all channels");
  property p_pulse; $fell(fo) |-> oeLen == FAULT_PULSE_CYC; endproperty
  a_pulse: assert property (p_pulse) else $error("fault pulse width wrong");
  property p_pulse_why; $rose(fo) |-> $past(seqDone); endproperty
  a_pulse_why: assert property (p_pulse_why) else $error("fault pulse before done");
  cover property ($rose(seqDone));
  cover property ($rose(fo));
  cover property ($fell(enable) && seqDone);
endmodule : crs_seq_chk

bind crs_sequencer crs_seq_chk #(.DONE_REL_CYCLES(DONE_REL_CYCLES)) i_chk (
  .core_clk(core_clk), .rst(rst), .enable(enable),
  .undervoltage_ok_input(undervoltage_ok_input),
  .shared_fault_bus_n_in(shared_fault_bus_n_in),
  .shared_fault_bus_n_oe(shared_fault_bus_n_oe),
  .chanEnable(chanEnable), .seqDone(seqDone));

// [bench/crs_sequencer_tb.sv]
// Purpose: self-checking bench for crs_sequencer
// Assumes: short lockout and release counts
// Notes:   times counted in cycles after each stimulus
`timescale 1ns/1ps
module crs_sequencer_tb;
  import crs_pkg::*;
  localparam int LOCK = 20;
  localparam int REL = 50;
  logic          core_clk = 1'b0;
  logic          rst = 1'b1;
  logic [1:0]    railUp = 2'b00;
  logic          nbrPull = 1'b0;
  logic [3:0]    uvOk = 4'hF;
  logic          enable, busN, busOe, seqDone;
  logic [3:0]    chanEnable;
  logic [3:0]    nxtChan;
  logic          nxtDone;
  crs_chan_cfg_s cfg [CHANNELS];
  int            onD [4] = '{0, 3, 7, 12};
  int            offD [4] = '{5, 0, 9, 2};
  int            tR [5], tF [5];
  int            miscompares = 0, totalChecks = 0;
  always #50 core_clk = ~core_clk;
  crs_far_side i_far (.railUp(railUp), .devOe(busOe), .nbrPull(nbrPull), .seqEnable(enable), .busN(busN));
  crs_sequencer #(.LOCKOUT_CYCLES(LOCK), .DONE_REL_CYCLES(REL)) i_dut (
    .core_clk(core_clk), .rst(rst), .enable(enable), .undervoltage_ok_input(uvOk),
    .chanCfg(cfg), .shared_fault_bus_n_in(busN), .shared_fault_bus_n_out(),
    .shared_fault_bus_n_oe(busOe), .chanEnable(chanEnable), .seqDone(seqDone));
  // listener only: next device in the chain, enabled by our done
  crs_sequencer #(.LOCKOUT_CYCLES(LOCK), .DONE_REL_CYCLES(REL)) i_nxt (
    .core_clk(core_clk), .rst(rst), .enable(seqDone), .undervoltage_ok_input(uvOk),
    .chanCfg(cfg), .shared_fault_bus_n_in(busN), .shared_fault_bus_n_out(),
    .shared_fault_bus_n_oe(), .chanEnable(nxtChan), .seqDone(nxtDone));
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s exp %0d got %0d", nm, exp, got);
    end
  endtask : chk
  // first rise and fall cycle of each output, 0 if none
  task automatic run(input int n);
    logic [4:0] prv, cur;
    tR = '{0, 0, 0, 0, 0};
    tF = '{0, 0, 0, 0, 0};
    prv = {seqDone, chanEnable};
    for (int c = 1; c <= n; c++) begin
      @(posedge core_clk);
      #1;
      cur = {seqDone, chanEnable};
      for (int i = 0; i < 5; i++) begin
        if (cur[i] && !prv[i] && tR[i] == 0) tR[i] = c;
        if (!cur[i] && prv[i] && tF[i] == 0) tF[i] = c;
      end
      prv = cur;
    end
  endtask : run
  task automatic t_on;
    railUp = 2'b11;
    run(200);
    for (int i = 1; i < 4; i++) chk("onGap", tR[i] - tR[0], onD[i]);
    chk("cascadeOn", {nxtDone, nxtChan}, 5'h1F);
    chk("lockout", tR[0] >= LOCK && tR[0] <= LOCK + 4, 1);
    chk("release", tR[4] - tR[3] >= REL && tR[4] - tR[3] <= REL + 4, 1);
  endtask : t_on
  task automatic t_off;
    railUp = 2'b01;
    run(40);
    chk("doneDrop", tF[4], 1);
    for (int i = 0; i < 4; i++) chk("offGap", tF[i] - tF[1], offD[i]);
    chk("cascadeOff", {nxtDone, nxtChan}, 5'h00);
  endtask : t_off
  task automatic t_uv_hold;
    uvOk = 4'hB;
    railUp = 2'b11;
    run(150);
    chk("uvHold", tR[0] + tR[1] + tR[2] + tR[3] + tR[4], 0);
    uvOk = 4'hF;
    run(150);
    chk("uvGo", tR[4] != 0, 1);
  endtask : t_uv_hold
  task automatic t_uv_fault;
    uvOk = 4'hD;
    run(250);
    for (int i = 1; i < 4; i++) chk("allOff", tF[i], tF[0]);
    chk("doneUvDrop", tF[4], 1);
    chk("offFast", tF[0] > 0 && tF[0] <= 3, 1);
    chk("noRestart", tR[0], 0);
    uvOk = 4'hF;
    run(150);
    chk("restart", tR[4] != 0, 1);
  endtask : t_uv_fault
  task automatic t_nbr;
    nbrPull = 1'b1;
    run(2);
    nbrPull = 1'b0;
    chk("nbrOff", {seqDone, chanEnable}, 5'h00);
    run(150);
    chk("nbrRestart", tR[4] != 0, 1);
  endtask : t_nbr
  task automatic reportAndStop;
    $display("checks %0d mismatches %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : reportAndStop
  initial begin
    foreach (cfg[i]) cfg[i] = '{onD[i][23:0], offD[i][23:0]};
    repeat (5) @(posedge core_clk);
    #1 rst = 1'b0;
    t_on();
    t_off();
    t_uv_hold();
    t_uv_fault();
    t_nbr();
    reportAndStop();
  end
  // whole run is about 1100 cycles
  initial begin
    repeat (3000) @(posedge core_clk);
    miscompares++;
    reportAndStop();
  end
endmodule : crs_sequencer_tb
